// >>> include/core_ops_pkg.sv
// Purpose: shared constants for the return/rotate/sleep/subtract unit
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   command word starts one instruction when the unit is idle
package core_ops_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CMD       = 8'h00;
	localparam logic [7:0] OFS_ACC       = 8'h04;
	localparam logic [7:0] OFS_STATUS    = 8'h08;
	localparam logic [7:0] OFS_PC        = 8'h0C;
	localparam logic [7:0] OFS_PUSH      = 8'h10;
	localparam logic [7:0] OFS_HEAD      = 8'h14;
	localparam logic [7:0] OFS_FILE_ADDR = 8'h18;
	localparam logic [7:0] OFS_FILE_DATA = 8'h1C;
	localparam logic [7:0] OFS_WATCHDOG  = 8'h20;
	localparam logic [7:0] OFS_PRESCALE  = 8'h24;

	// command word fields
	localparam int CMD_OP_LSB   = 0;
	localparam int CMD_DEST_BIT = 3;
	localparam int CMD_FILE_LSB = 4;
	localparam int CMD_LIT_LSB  = 16;

	// status register bit positions
	localparam int ST_CARRY   = 0;
	localparam int ST_NIBBLE  = 1;
	localparam int ST_ZERO    = 2;
	localparam int ST_PDOWN   = 3;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_BUSY    = 5;

	// sizes, reset values, sleep clear values and prescaler top
	localparam int PC_W        = 13;
	localparam int SP_W        = 4;
	localparam int STACK_DEPTH = 16;
	localparam int FILE_DEPTH  = 128;
	localparam logic       PDOWN_RST   = 1'b1;
	localparam logic       TIMEOUT_RST = 1'b1;
	localparam logic [7:0] WATCHDOG_CLR = 8'h00;
	localparam logic [7:0] PRESCALE_CLR = 8'h00;
	localparam logic [7:0] PRESCALE_TOP = 8'hFF;

	// instruction codes in the command word
	typedef enum logic [2:0] {
		OP_RETURN_IMM = 3'b000,
		OP_RETURN     = 3'b001,
		OP_ROTATE     = 3'b010,
		OP_SLEEP      = 3'b011,
		OP_SUBTRACT   = 3'b100
	} op_t;

	// execution sequencer
	typedef enum logic [1:0] {
		S_IDLE   = 2'b00,
		S_EXEC   = 2'b01,
		S_SECOND = 2'b10
	} seq_t;
endpackage

// >>> hdl/core_ops.sv
// Purpose: executes return, rotate, sleep and subtract over an apb port
// Assumes: pclk 200 MHz, one pclk per instruction cycle
// Notes:   pready is always high; unmapped addresses answer pslverr
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps

// Functional notes
// - return-with-immediate loads its 8-bit literal into acc, flags untouched
// - return-with-immediate reloads pc from stack head; two cycles
// - return pops stack into pc, no flags changed, two cycles
// - rotate right through carry; carry is the only flag changed
// - rotate destination 0 writes acc, 1 writes the file register
// - sleep clears watchdog counter to 00h and its prescaler
// - sleep clears powerdown flag, sets timeout flag, no other flag changed
// - subtract computes file minus acc, updates carry, nibble, zero
// - subtract destination 0 writes acc, 1 writes the file register
// - carry set when acc <= file; nibble flag same on bits 3:0
module core_ops
	import core_ops_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	import core_ops_pkg::*;

	// register map, one aligned 32-bit word each, data in the low bits
	//   CMD       write only: starts one instruction while idle
	//             [2:0] op code, 5 to 7 act as no-ops
	//             [3] destination, 0 acc, 1 file register
	//             [10:4] file register index
	//             [23:16] literal for return-with-immediate
	//   ACC       read/write accumulator, [7:0]
	//   STATUS    read/write flags, busy bit read only
	//             [0] carry, [1] nibble borrow, [2] zero
	//             [3] powerdown, [4] timeout, [5] busy
	//   PC        read only program counter
	//   PUSH      write only: pushes a return address on the stack
	//   HEAD      read only: current stack head
	//   FILE_ADDR read/write index used by FILE_DATA
	//   FILE_DATA read/write file register at FILE_ADDR
	//   WATCHDOG  read only watchdog count
	//   PRESCALE  read only watchdog prescaler
	// writes to read-only words are dropped without an error;
	// any other address answers with pslverr and reads as zero
	//
	// sequencing
	//   a CMD write is taken at the access edge and raises busy;
	//   all effects land together at the next edge;
	//   both return kinds then stay busy for one more cycle,
	//   so every return spends two instruction cycles;
	//   a CMD write while busy is ignored, nothing is queued
	//
	// hazards
	//   instruction effects override a same-cycle software write
	//   to ACC, STATUS or FILE_DATA, so hardware always wins;
	//   the stack pointer wraps, an empty pop reads entry 15

	typedef struct packed {
		seq_t                           seq;
		op_t                            op;
		logic                           dest;
		logic [6:0]                     fsel;
		logic [7:0]                     lit;
		logic [7:0]                     acc;
		logic                           carry;
		logic                           nibble_borrow_flag;
		logic                           zero;
		logic                           powerdown_flag;
		logic                           timeout_flag;
		logic [PC_W-1:0]                pc;
		logic [SP_W-1:0]                sp;
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
		logic [FILE_DEPTH-1:0][7:0]     file;
		logic [6:0]                     faddr;
		logic [7:0]                     watchdog_counter;
		logic [7:0]                     prescale;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	// register address check shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		if (a == OFS_CMD) begin
			mapped = 1'b1;
		end else if (a == OFS_ACC) begin
			mapped = 1'b1;
		end else if (a == OFS_STATUS) begin
			mapped = 1'b1;
		end else if (a == OFS_PC) begin
			mapped = 1'b1;
		end else if (a == OFS_PUSH) begin
			mapped = 1'b1;
		end else if (a == OFS_HEAD) begin
			mapped = 1'b1;
		end else if (a == OFS_FILE_ADDR) begin
			mapped = 1'b1;
		end else if (a == OFS_FILE_DATA) begin
			mapped = 1'b1;
		end else if (a == OFS_WATCHDOG) begin
			mapped = 1'b1;
		end else if (a == OFS_PRESCALE) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0; // hole in the map
		end
	endfunction

	logic            access;
	logic            wr;
	logic [PC_W-1:0] stack_head;
	logic [7:0]      fval;
	logic [8:0]      diff;
	logic [4:0]      ndiff;
	logic [7:0]      rot;
	logic [7:0]      status_word;

	assign access = psel && penable;
	assign wr = access && pwrite && mapped(paddr);
	assign stack_head = st_r.stack[st_r.sp - 4'd1];
	assign fval = st_r.file[st_r.fsel];
	// borrow-free subtract: bit 8 clear means acc <= file
	assign diff = {1'b0, fval} - {1'b0, st_r.acc};
	assign ndiff = {1'b0, fval[3:0]} - {1'b0, st_r.acc[3:0]};
	assign rot = {st_r.carry, fval[7:1]};

	// status bits as software sees them
	always_comb begin
		status_word = 8'h00;
		status_word[ST_CARRY] = st_r.carry;
		status_word[ST_NIBBLE] = st_r.nibble_borrow_flag;
		status_word[ST_ZERO] = st_r.zero;
		status_word[ST_PDOWN] = st_r.powerdown_flag;
		status_word[ST_TIMEOUT] = st_r.timeout_flag;
		status_word[ST_BUSY] = (st_r.seq != S_IDLE); // busy, read only
	end

	// apb answers in the access cycle
	assign pready = 1'b1;
	assign pslverr = access && !mapped(paddr);

	// read data mux
	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == OFS_ACC) begin
			prdata[7:0] = st_r.acc;
		end else if (paddr == OFS_STATUS) begin
			prdata[7:0] = status_word;
		end else if (paddr == OFS_PC) begin
			prdata[PC_W-1:0] = st_r.pc;
		end else if (paddr == OFS_HEAD) begin
			prdata[PC_W-1:0] = stack_head;
		end else if (paddr == OFS_FILE_ADDR) begin
			prdata[6:0] = st_r.faddr;
		end else if (paddr == OFS_FILE_DATA) begin
			prdata[7:0] = st_r.file[st_r.faddr];
		end else if (paddr == OFS_WATCHDOG) begin
			prdata[7:0] = st_r.watchdog_counter;
		end else if (paddr == OFS_PRESCALE) begin
			prdata[7:0] = st_r.prescale;
		end
		if (!access || pwrite || !mapped(paddr)) begin
			prdata = 32'h0000_0000;
		end
	end

	// next state: software writes first, then instruction effects win
	always_comb begin
		st_nxt = st_r;
		// free-running watchdog with its prescaler
		// prescaler steps every clock, watchdog steps on its wrap;
		// sleep below restarts both from zero in the same edge
		st_nxt.prescale = st_r.prescale + 8'h01;
		if (st_r.prescale == PRESCALE_TOP) begin
			st_nxt.watchdog_counter = st_r.watchdog_counter + 8'h01;
		end
		// register writes
		if (wr) begin
			if (paddr == OFS_CMD && st_r.seq == S_IDLE) begin
				st_nxt.op = op_t'(pwdata[CMD_OP_LSB +: 3]);
				st_nxt.dest = pwdata[CMD_DEST_BIT];
				st_nxt.fsel = pwdata[CMD_FILE_LSB +: 7];
				st_nxt.lit = pwdata[CMD_LIT_LSB +: 8];
				st_nxt.seq = S_EXEC;
			end else if (paddr == OFS_ACC) begin
				st_nxt.acc = pwdata[7:0];
			end else if (paddr == OFS_STATUS) begin
				st_nxt.carry = pwdata[ST_CARRY];
				st_nxt.nibble_borrow_flag = pwdata[ST_NIBBLE];
				st_nxt.zero = pwdata[ST_ZERO];
				st_nxt.powerdown_flag = pwdata[ST_PDOWN];
				st_nxt.timeout_flag = pwdata[ST_TIMEOUT];
			end else if (paddr == OFS_PUSH) begin
				st_nxt.stack[st_r.sp] = pwdata[PC_W-1:0];
				st_nxt.sp = st_r.sp + 4'd1;
			end else if (paddr == OFS_FILE_ADDR) begin
				st_nxt.faddr = pwdata[6:0];
			end else if (paddr == OFS_FILE_DATA) begin
				st_nxt.file[st_r.faddr] = pwdata[7:0];
			end
		end
		// instruction sequencer
		// idle waits for CMD, exec applies all effects at once,
		// second only keeps busy high for the return kinds
		case (st_r.seq)
			S_IDLE: begin
				st_nxt.seq = st_nxt.seq;
			end
			S_EXEC: begin
				st_nxt.seq = S_IDLE;
				case (st_r.op)
					OP_RETURN_IMM: begin
						st_nxt.acc = st_r.lit;
						st_nxt.pc = stack_head;
						st_nxt.sp = st_r.sp - 4'd1;
						st_nxt.seq = S_SECOND;
					end
					OP_RETURN: begin
						st_nxt.pc = stack_head;
						st_nxt.sp = st_r.sp - 4'd1;
						st_nxt.seq = S_SECOND;
					end
					OP_ROTATE: begin
						st_nxt.carry = fval[0];
						if (st_r.dest) begin
							st_nxt.file[st_r.fsel] = rot;
						end else begin
							st_nxt.acc = rot;
						end
					end
					OP_SLEEP: begin
						st_nxt.watchdog_counter = WATCHDOG_CLR;
						st_nxt.prescale = PRESCALE_CLR;
						st_nxt.powerdown_flag = 1'b0;
						st_nxt.timeout_flag = 1'b1;
					end
					OP_SUBTRACT: begin
						st_nxt.carry = !diff[8];
						st_nxt.nibble_borrow_flag = !ndiff[4];
						st_nxt.zero = (diff[7:0] == 8'h00);
						if (st_r.dest) begin
							st_nxt.file[st_r.fsel] = diff[7:0];
						end else begin
							st_nxt.acc = diff[7:0];
						end
					end
					default: begin
						st_nxt.seq = S_IDLE;
					end
				endcase
			end
			S_SECOND: begin
				st_nxt.seq = S_IDLE; // second instruction cycle
			end
			default: begin
				st_nxt.seq = S_IDLE;
			end
		endcase
	end

	// state register
	// reset leaves everything zero but the powerdown and timeout
	// flags, which come up set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.powerdown_flag <= PDOWN_RST;
			st_r.timeout_flag <= TIMEOUT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule

// >>> tb/core_ops_monitor.sv
// Purpose: port-level checks of the instruction unit
// Assumes: bench reads STATUS, ACC, WATCHDOG in turn after each command
// Notes:   flags before a command come from the last STATUS read
`timescale 1ns/1ps
module core_ops_monitor
	import core_ops_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic       wr_c, rd_s, rd_a, rd_w, c_r;
	logic [4:0] st_r;
	logic [7:0] lit_r;
	// decoded access cycles
	assign wr_c = psel && penable && pwrite && paddr == OFS_CMD;
	assign rd_s = psel && penable && !pwrite && paddr == OFS_STATUS;
	assign rd_a = psel && penable && !pwrite && paddr == OFS_ACC;
	assign rd_w = psel && penable && !pwrite && paddr == OFS_WATCHDOG;
	// last seen flags, carry and literal at command time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= 5'h18;
			c_r <= 1'b0;
			lit_r <= 8'h00;
		end else begin
			if (rd_s) st_r <= prdata[4:0];
			if (wr_c) c_r <= st_r[0];
			if (wr_c) lit_r <= pwdata[23:16];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_RET_BUSY: assert property ((wr_c && pwdata[2:1] == 2'b00) ##2 rd_s
		|-> prdata[ST_BUSY]) else $error("return not busy in second cycle");
	AST_ONE_CYCLE: assert property ((wr_c && pwdata[2:0] inside {3'd2, 3'd3,
		3'd4}) ##2 rd_s |-> !prdata[ST_BUSY]) else $error("busy too long");
	AST_RET_FLAGS: assert property ((wr_c && pwdata[2:1] == 2'b00) ##2 rd_s
		|-> prdata[4:0] == st_r) else $error("return changed flags");
	AST_ROT_FLAGS: assert property ((wr_c && pwdata[2:0] == 3'd2) ##2 rd_s
		|-> prdata[4:1] == st_r[4:1]) else $error("rotate changed flags");
	AST_SLEEP_FLAGS: assert property ((wr_c && pwdata[2:0] == 3'd3) ##2 rd_s
		|-> prdata[4:0] == {2'b10, st_r[2:0]}) else $error("sleep flags");
	AST_LIT_ACC: assert property ((wr_c && pwdata[2:0] == 3'd0) ##2 rd_s ##2
		rd_a |-> prdata[7:0] == lit_r) else $error("literal not in acc");
	AST_ROT_MSB: assert property ((wr_c && pwdata[3:0] == 4'h2) ##2 rd_s ##2
		rd_a |-> prdata[7] == c_r) else $error("old carry not in msb");
	AST_SUB_ZERO: assert property ((wr_c && pwdata[3:0] == 4'h4) ##2 rd_s ##2
		rd_a |-> (prdata[7:0] == 8'h00) == st_r[ST_ZERO]) else $error("zero");
	AST_SLEEP_WDT: assert property ((wr_c && pwdata[2:0] == 3'd3) ##6 rd_w
		|-> prdata[7:0] == WATCHDOG_CLR) else $error("watchdog not cleared");
	COV_SUB: cover property (wr_c && pwdata[2:0] == 3'd4);
	COV_SLEEP: cover property (wr_c && pwdata[2:0] == 3'd3);
	COV_RET: cover property (wr_c && pwdata[2:0] == 3'd1);
endmodule
bind core_ops core_ops_monitor mon_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// >>> tb/testbench.sv
// Purpose: random and corner tests of the instruction unit over apb
// Assumes: slave latency taken from pready, never counted
// Notes:   first ten commands use equal operands for zero results
`timescale 1ns/1ps
module testbench;
	import core_ops_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err;
	int          miscompares = 0, n_tests = 0, cyc = 0;
	core_ops dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	always #2.5 pclk = ~pclk;
	// hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one transfer; bus stays selected until the next setup
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
	endtask
	// expected {flags, acc, file} after one command
	function automatic logic [20:0] model(input logic [2:0] op,
		input logic dst, input logic [7:0] lit, w, f, input logic [4:0] st);
		logic [7:0] r;
		r = f;
		case (op)
		3'd0: w = lit;
		3'd2: begin
			r = {st[0], f[7:1]};
			st[0] = f[0];
		end
		3'd3: st[4:3] = 2'b10;
		3'd4: begin
			r = f - w;
			st[2:0] = {r == 8'h00, w[3:0] <= f[3:0], w <= f};
		end
		default: ;
		endcase
		if (op == 3'd2 || op == 3'd4) begin
			if (dst) f = r;
			else w = r;
		end
		return {st, w, f};
	endfunction
	initial begin
		logic [7:0]  f, w, lit;
		logic [4:0]  st;
		logic [2:0]  op;
		logic [12:0] ret;
		logic        dst;
		logic [20:0] e;
		void'($urandom(32'hEB44));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 50; i++) begin
			op = 3'(i % 5);
			{dst, lit, ret} = 22'($urandom);
			f = 8'($urandom);
			w = (i < 10) ? f : 8'($urandom);
			st = 5'($urandom);
			apb(1'b1, OFS_ACC, {24'h0, w});
			apb(1'b1, OFS_STATUS, {27'h0, st});
			apb(1'b1, OFS_FILE_ADDR, 32'(i));
			apb(1'b1, OFS_FILE_DATA, {24'h0, f});
			apb(1'b1, OFS_PUSH, {19'h0, ret});
			apb(1'b0, OFS_STATUS, 32'h0);
			e = model(op, dst, lit, w, f, st);
			apb(1'b1, OFS_CMD, {8'h0, lit, 5'h0, 7'(i), dst, op});
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(32'(rd[4:0]), 32'(e[20:16]));
			apb(1'b0, OFS_ACC, 32'h0);
			chk(32'(rd[7:0]), 32'(e[15:8]));
			apb(1'b0, OFS_WATCHDOG, 32'h0);
			apb(1'b0, OFS_FILE_DATA, 32'h0);
			chk(32'(rd[7:0]), 32'(e[7:0]));
			apb(1'b0, OFS_PC, 32'h0);
			if (op < 3'd2) chk(rd, 32'(ret));
		end
		apb(1'b0, 8'h3C, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		summarize();
	end
endmodule
